// ===== src/bus_fault_ctrl.sv
// Processor end: bus cycle sequencing, termination decode, fault handling.
// Assumes the system end shares ref_clk and drives terminations synchronously.
// Operation
// - Breakpoint: acknowledge read, kind 3, zero address
// - Breakpoint ack or error gives illegal instruction
// - Decode pins: error, retry, normal, wait
// - System errors cycles nobody acknowledges in time
// - Bus error ends access, aborts line
// - Prefetch error deferred until instruction used
// - Unneeded later line word error: not cached
// - Misaligned operand error excepts immediately
// - Write or requested read error excepts immediately
// - Replaced line invalidated before fill starts
// - Dirty line restored after failed fill
// - Push error: keep replaced, invalidate flushed
// - Write-through error keeps line with data
// - Retry reruns same cycle, except snooped replacement push
// - Locked cycles retried separately, hold stays
// - Line retry after first word is error
// - Burst-inhibited line retries only first transfer
// - Grant negated with retry: release, retry later
// - Error while stacking halts, state code 5
// - Halted: release bus when grant negated
// - Errors inside handler are ordinary errors
// - Retries count toward double fault only as line retries after first word
// - Sample terminations every edge, wait otherwise
// - Arbiter negates grant before final termination
`timescale 1ns/1ps
`default_nettype none
`include "bus_term_defs.svh"

module bus_fault_ctrl
    import bus_term_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    // Bus link
    bus_term_if.proc         link,
    // Access request
    input  wire logic        reqValid,
    input  var  access_e     reqKind,
    input  wire logic [31:0] reqAddr,
    input  wire logic [2:0]  reqModifier,
    input  wire logic        reqLine,
    input  wire logic        reqLock,
    input  wire logic        reqPrefetch,
    input  wire logic        reqMisaligned,
    input  wire logic        reqNeedAny,
    input  wire logic [1:0]  reqNeedBeat,
    input  wire logic        reqReplaceValid,
    input  wire logic        reqReplaceDirty,
    input  wire logic        reqWriteThrough,
    input  wire logic        reqStacking,
    output logic             reqReady,
    // Execution side events
    input  wire logic        pushSnooped,
    input  wire logic        instrUsed,
    input  wire logic        instrDiscard,
    // Completion and exceptions
    output logic             doneValid,
    output var  term_e       doneStatus,
    output logic             accessErrExc,
    output logic             illegalExc,
    output logic             deferredPending,
    output logic             halted,
    // Cache actions
    output logic             lineInvalidate,
    output logic             lineNotCached,
    output logic             dirtyRestore,
    output logic             lineKeepValid
);

    // ****************************************
    // Request capture and decode
    // ****************************************
    bus_state_e  state;
    access_e     curKind;
    logic [31:0] curAddr;
    logic [2:0]  curMod;
    logic [1:0]  beat;
    logic        curLine, curLock, curPrefetch, curMisaligned, curNeedAny;
    logic        curReplaceDirty, curWriteThrough, curStacking;
    logic [1:0]  curNeedBeat;

    term_e term;
    logic  retryAsErr, effErr, effRetry, lastBeat, isBkpt, isRead, accept, next_cycleActive;

    assign term       = decode_term(link.transferAck_n, link.transferErrorAck_n);
    assign retryAsErr = curLine && (beat != 2'h0);
    assign effErr     = (term == TERM_ERROR) || (term == TERM_RETRY && retryAsErr);
    assign effRetry   = (term == TERM_RETRY) && !retryAsErr;
    assign lastBeat   = !curLine || (beat == `BT_LINE_LAST);
    assign isBkpt     = (curKind == ACC_BREAKPOINT_OP);
    assign isRead     = (curKind == ACC_READ) || isBkpt;
    assign accept     = (state == ST_IDLE) && reqValid;
    // Cycle stays open; outside halt, pins driven only while it does
    assign next_cycleActive = (state == ST_ARB && !link.busOwnershipGrant_n) || state == ST_XFER
        || (state == ST_DATA && !effErr && !(term == TERM_NORMAL && lastBeat)
            && !(effRetry && (link.busOwnershipGrant_n
                 || (curKind == ACC_PUSH_REPL && pushSnooped))));

    always_ff @(posedge ref_clk) begin
        if (ce && accept) begin
            curKind         <= reqKind;
            curAddr         <= reqAddr;
            curMod          <= reqModifier;
            curLine         <= reqLine;
            curLock         <= reqLock;
            curPrefetch     <= reqPrefetch;
            curMisaligned   <= reqMisaligned;
            curNeedAny      <= reqNeedAny;
            curNeedBeat     <= reqNeedBeat;
            curReplaceDirty <= reqReplaceDirty;
            curWriteThrough <= reqWriteThrough;
            curStacking     <= reqStacking;
        end
    end

    // ****************************************
    // Bus sequencer
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state <= ST_IDLE;
            beat  <= 2'h0;
        end else if (ce) begin
            unique case (state)
                ST_IDLE: begin
                    beat <= 2'h0;
                    if (reqValid) begin
                        state <= ST_ARB;
                    end
                end
                ST_ARB: begin
                    if (!link.busOwnershipGrant_n) begin
                        state <= ST_XFER;
                    end
                end
                ST_XFER: begin
                    state <= ST_DATA;
                end
                ST_DATA: begin
                    if (effErr) begin
                        state <= curStacking ? ST_HALT : ST_IDLE;
                    end else if (effRetry) begin
                        if (curKind == ACC_PUSH_REPL && pushSnooped) begin
                            state <= ST_IDLE;
                        end else if (link.busOwnershipGrant_n) begin
                            state <= ST_ARB;
                        end else begin
                            state <= ST_XFER;
                        end
                    end else if (term == TERM_NORMAL) begin
                        if (lastBeat) begin
                            state <= ST_IDLE;
                        end else begin
                            beat <= beat + 2'h1;
                        end
                    end
                end
                ST_HALT: begin
                    state <= ST_HALT;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // Bus pins
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            link.busRequest      <= 1'b0;
            link.transferStart   <= 1'b0;
            link.cycleActive     <= 1'b0;
            link.address         <= 32'h0000_0000;
            link.transferKindHi  <= 1'b0;
            link.transferKindLo  <= 1'b0;
            link.accessModifier  <= 3'h0;
            link.readNotWrite    <= 1'b1;
            link.indivisibleHold <= 1'b0;
            link.procStateOut    <= `BT_PST_RUN;
            link.driveEn_n       <= 1'b1;
        end else if (ce) begin
            link.busRequest    <= (state == ST_IDLE && reqValid) || state == ST_ARB
                                  || (state == ST_DATA && effRetry && link.busOwnershipGrant_n);
            link.transferStart <= (state == ST_ARB && !link.busOwnershipGrant_n)
                                  || (state == ST_DATA && effRetry && !link.busOwnershipGrant_n
                                      && !(curKind == ACC_PUSH_REPL && pushSnooped));
            link.cycleActive   <= next_cycleActive;
            if (state == ST_ARB) begin
                link.address        <= isBkpt ? `BT_BREAKPOINT_OP_ADDR : curAddr;
                link.accessModifier <= isBkpt ? `BT_BREAKPOINT_OP_MOD : curMod;
                {link.transferKindHi, link.transferKindLo} <= isBkpt ? `BT_KIND_ACK
                                                                     : `BT_KIND_NORMAL;
                link.readNotWrite   <= isRead;
            end
            if (state == ST_IDLE) begin
                link.indivisibleHold <= reqValid && reqLock;
            end
            if (state == ST_HALT || (state == ST_DATA && effErr && curStacking)) begin
                link.procStateOut <= `BT_PST_DBLFAULT;
                link.driveEn_n    <= link.busOwnershipGrant_n;
            end else begin
                link.driveEn_n    <= !next_cycleActive;
            end
        end
    end

    // ****************************************
    // Completion, exceptions, cache actions
    // ****************************************
    logic endErr;
    assign endErr = ce && state == ST_DATA && effErr && !curStacking;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            reqReady       <= 1'b0;
            doneValid      <= 1'b0;
            doneStatus     <= TERM_WAIT;
            accessErrExc   <= 1'b0;
            illegalExc     <= 1'b0;
            halted         <= 1'b0;
            lineInvalidate <= 1'b0;
            lineNotCached  <= 1'b0;
            dirtyRestore   <= 1'b0;
            lineKeepValid  <= 1'b0;
        end else if (ce) begin
            reqReady   <= (state == ST_IDLE) && !reqValid;
            doneValid  <= state == ST_DATA && (effErr || (term == TERM_NORMAL && lastBeat)
                          || (effRetry && curKind == ACC_PUSH_REPL && pushSnooped));
            doneStatus <= effErr ? TERM_ERROR : term;
            illegalExc <= state == ST_DATA && isBkpt && !curStacking
                          && (effErr || term == TERM_NORMAL);
            accessErrExc <= (endErr && !isBkpt && !curPrefetch
                             && (!isRead || curMisaligned || !curLine
                                 || (curNeedAny && curNeedBeat == beat)))
                            || (deferredPending && instrUsed);
            lineNotCached <= endErr && isRead && !isBkpt && curLine && !curPrefetch
                             && !curMisaligned && !(curNeedAny && curNeedBeat == beat);
            lineInvalidate <= (accept && reqLine && reqReplaceValid && reqKind == ACC_READ)
                              || (endErr && curKind == ACC_PUSH_FLUSH);
            dirtyRestore  <= endErr && curKind == ACC_READ && curLine && curReplaceDirty;
            lineKeepValid <= endErr && (curKind == ACC_PUSH_REPL
                             || (curKind == ACC_WRITE && curWriteThrough));
            halted <= halted || (state == ST_DATA && effErr && curStacking);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            deferredPending <= 1'b0;
        end else if (ce) begin
            if (endErr && curPrefetch) begin
                deferredPending <= 1'b1;
            end else if (instrUsed || instrDiscard) begin
                deferredPending <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// ===== common/bus_term_defs.svh
// Constants for the bus termination and fault control pair.
// Assumes inclusion by bare name; definitions only.
`ifndef BUS_TERM_DEFS_SVH
`define BUS_TERM_DEFS_SVH

// ****************************************
// Transfer attributes
// ****************************************
`define BT_KIND_NORMAL   2'h0
`define BT_KIND_ACK      2'h3
`define BT_BREAKPOINT_OP_ADDR     32'h0000_0000
`define BT_BREAKPOINT_OP_MOD      3'h0

// ****************************************
// Processor state codes
// ****************************************
`define BT_PST_RUN       4'h0
`define BT_PST_DBLFAULT  4'h5

// ****************************************
// Line transfers and timing
// ****************************************
`define BT_LINE_LAST     2'h3
`define BT_CLK_NS        50
`define BT_TIMEOUT_NS    2000

`endif

// ===== common/bus_term_pkg.sv
// Types shared by both ends of the bus termination link.
// Assumes nothing beyond a SystemVerilog compiler.
package bus_term_pkg;

    // Decoded termination outcome
    typedef enum logic [1:0] {
        TERM_WAIT   = 2'h0,
        TERM_NORMAL = 2'h1,
        TERM_ERROR  = 2'h2,
        TERM_RETRY  = 2'h3
    } term_e;

    // Kind of access requested of the bus controller
    typedef enum logic [2:0] {
        ACC_READ       = 3'h0,
        ACC_WRITE      = 3'h1,
        ACC_BREAKPOINT_OP       = 3'h2,
        ACC_PUSH_REPL  = 3'h3,
        ACC_PUSH_FLUSH = 3'h4
    } access_e;

    // Bus sequencer states, Gray along idle-arb-start-data
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ARB  = 3'b001,
        ST_XFER = 3'b011,
        ST_DATA = 3'b010,
        ST_HALT = 3'b110
    } bus_state_e;

    // Active-low acknowledge and error pins to an outcome
    function automatic term_e decode_term(input logic ack_n, input logic err_n);
        term_e t;
        t = TERM_WAIT;
        unique case ({ack_n, err_n})
            2'b10:   t = TERM_ERROR;
            2'b00:   t = TERM_RETRY;
            2'b01:   t = TERM_NORMAL;
            2'b11:   t = TERM_WAIT;
            default: t = TERM_WAIT;
        endcase
        return t;
    endfunction

endpackage

// ===== common/bus_term_if.sv
// External bus link between the processor end and the system logic end.
// Assumes both ends run on the same bus clock.
`timescale 1ns/1ps
`default_nettype none

interface bus_term_if;
    // Processor driven
    logic        busRequest;
    logic        transferStart;
    logic        cycleActive;
    logic [31:0] address;
    logic        transferKindHi;
    logic        transferKindLo;
    logic [2:0]  accessModifier;
    logic        readNotWrite;
    logic        indivisibleHold;
    logic [3:0]  procStateOut;
    logic        driveEn_n;
    // System driven
    logic        transferAck_n;
    logic        transferErrorAck_n;
    logic        busOwnershipGrant_n;

    modport proc (
        output busRequest, transferStart, cycleActive, address, transferKindHi,
               transferKindLo, accessModifier, readNotWrite, indivisibleHold,
               procStateOut, driveEn_n,
        input  transferAck_n, transferErrorAck_n, busOwnershipGrant_n
    );

    modport sys (
        input  busRequest, transferStart, cycleActive, address, transferKindHi,
               transferKindLo, accessModifier, readNotWrite, indivisibleHold,
               procStateOut, driveEn_n,
        output transferAck_n, transferErrorAck_n, busOwnershipGrant_n
    );
endinterface

`default_nettype wire

// ===== src/bus_term_responder.sv
// System end: arbiter grant and cycle termination for the processor end.
// Assumes the processor end shares ref_clk; user logic chooses every answer but the timeout error.
`timescale 1ns/1ps
`default_nettype none
`include "bus_term_defs.svh"

module bus_term_responder
    import bus_term_pkg::*;
#(
    parameter int TIMEOUT_NS = `BT_TIMEOUT_NS
)(
    // Clock, reset, enable
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    // Bus link
    bus_term_if.sys          link,
    // User control
    input  wire logic        grantEnable,
    input  wire logic        respValid,
    input  var  term_e       respKind,
    // Observation
    output logic             cycleSeen,
    output logic [31:0]      seenAddr,
    output logic             seenAck,
    output logic             timedOut
);

    localparam int TO_CYC_RAW = TIMEOUT_NS / `BT_CLK_NS;
    localparam int TO_CYC     = (TO_CYC_RAW < 1) ? 1 : TO_CYC_RAW;

    if (TO_CYC > 4095) begin : g_bad_timeout
        $error("TIMEOUT_NS too long for the 12-bit counter");
    end

    logic [11:0] waitCnt;
    logic        termIdle, canAnswer, grantSettled;

    assign termIdle     = link.transferAck_n && link.transferErrorAck_n;
    assign canAnswer    = link.cycleActive && !link.transferStart && termIdle;
    assign grantSettled = (grantEnable == !link.busOwnershipGrant_n);

    // ****************************************
    // Grant and termination pins
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            link.busOwnershipGrant_n <= 1'b1;
            link.transferAck_n       <= 1'b1;
            link.transferErrorAck_n  <= 1'b1;
            timedOut                 <= 1'b0;
        end else if (ce) begin
            link.busOwnershipGrant_n <= !grantEnable;
            link.transferAck_n       <= 1'b1;
            link.transferErrorAck_n  <= 1'b1;
            timedOut                 <= 1'b0;
            if (canAnswer && respValid && grantSettled) begin
                link.transferAck_n      <= !(respKind == TERM_NORMAL || respKind == TERM_RETRY);
                link.transferErrorAck_n <= !(respKind == TERM_ERROR || respKind == TERM_RETRY);
            end else if (canAnswer && waitCnt >= 12'(TO_CYC)) begin
                link.transferErrorAck_n <= 1'b0;
                timedOut                <= 1'b1;
            end
        end
    end

    // ****************************************
    // Cycle watch
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            waitCnt   <= 12'h000;
            cycleSeen <= 1'b0;
            seenAddr  <= 32'h0000_0000;
            seenAck   <= 1'b0;
        end else if (ce) begin
            cycleSeen <= link.transferStart;
            if (link.transferStart || !termIdle) begin
                waitCnt <= 12'h000;
            end else if (link.cycleActive && waitCnt != 12'hfff) begin
                waitCnt <= waitCnt + 12'h001;
            end
            if (link.transferStart) begin
                seenAddr <= link.address;
                seenAck  <= ({link.transferKindHi, link.transferKindLo} == `BT_KIND_ACK);
            end
        end
    end

endmodule

`default_nettype wire

// ===== tb/bus_term_monitor.sv
// Checker for the link between the processor end and the system end.
// Assumes the bench instantiates it beside the interface, one clock.
`timescale 1ns/1ps
`default_nettype none

module bus_term_monitor (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        resetn,
    // Link signals
    input wire logic        transferStart,
    input wire logic        cycleActive,
    input wire logic [31:0] address,
    input wire logic        transferKindHi,
    input wire logic        transferKindLo,
    input wire logic [2:0]  accessModifier,
    input wire logic        readNotWrite,
    input wire logic [3:0]  procStateOut,
    input wire logic        driveEn_n,
    input wire logic        transferAck_n,
    input wire logic        transferErrorAck_n,
    input wire logic        busOwnershipGrant_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // ****************************************
    // Properties
    // ****************************************
    property p_start_pulse;
        transferStart |-> cycleActive && !driveEn_n ##1 !transferStart;
    endproperty
    property p_term_pulse;
        !transferAck_n |=> transferAck_n && transferErrorAck_n;
    endproperty
    property p_term_in_cycle;
        !(transferAck_n && transferErrorAck_n) |-> cycleActive && !transferStart;
    endproperty
    property p_breakpoint_op;
        transferStart && transferKindHi && transferKindLo
            |-> address == 32'h0 && accessModifier == 3'h0 && readNotWrite;
    endproperty
    property p_retry;
        cycleActive && !transferAck_n && !transferErrorAck_n && !busOwnershipGrant_n
            |=> transferStart && $stable(address);
    endproperty
    property p_err_ends;
        cycleActive && transferAck_n && !transferErrorAck_n |=> !transferStart;
    endproperty
    property p_wait;
        cycleActive && !transferStart && transferAck_n && transferErrorAck_n
            |=> cycleActive;
    endproperty
    property p_halt_hold;
        procStateOut == 4'h5 |=> procStateOut == 4'h5;
    endproperty
    property p_halt_release;
        procStateOut == 4'h5 && busOwnershipGrant_n |-> ##[0:2] driveEn_n;
    endproperty

    // ****************************************
    // Assertions
    // ****************************************
    a_start_pulse: assert property (p_start_pulse) else $error("start pulse bad");
    a_term_pulse: assert property (p_term_pulse) else $error("ack not a pulse");
    a_term_in_cycle: assert property (p_term_in_cycle) else $error("stray end");
    a_breakpoint_op: assert property (p_breakpoint_op) else $error("breakpoint_op attributes bad");
    a_retry: assert property (p_retry) else $error("retry not rerun");
    a_err_ends: assert property (p_err_ends) else $error("error not final");
    a_wait: assert property (p_wait) else $error("wait state lost");
    a_halt_hold: assert property (p_halt_hold) else $error("halt code lost");
    a_halt_release: assert property (p_halt_release) else $error("bus held");

    // ****************************************
    // Coverage
    // ****************************************
    c_retry: cover property (cycleActive && !transferAck_n && !transferErrorAck_n);
    c_breakpoint_op: cover property (transferStart && transferKindHi && transferKindLo);
    c_halt: cover property (procStateOut == 4'h5 && busOwnershipGrant_n);
endmodule

`default_nettype wire

// ===== tb/bus_termination_fault_control_tb_top.sv
// Bench joining both ends through the interface, with the checker beside it.
// Assumes the shared package, interface and both design ends are compiled first.
`timescale 1ns/1ps
`default_nettype none

module bus_termination_fault_control_tb_top;
    import bus_term_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic        ref_clk, resetn, ce, reqValid, reqLine, reqLock, reqPrefetch;
    logic        reqMisaligned, reqNeedAny, reqReplaceValid, reqReplaceDirty;
    logic        reqWriteThrough, reqStacking, reqReady, pushSnooped, instrUsed;
    logic        instrDiscard, doneValid, accessErrExc, illegalExc, deferredPending;
    logic        halted, lineInvalidate, lineNotCached, dirtyRestore, lineKeepValid;
    logic        grantEnable, respValid, cycleSeen, seenAck, timedOut, clr, ps;
    logic [31:0] reqAddr, seenAddr;
    logic [2:0]  reqModifier;
    logic [1:0]  reqNeedBeat;
    logic [6:0]  seen;
    access_e     reqKind;
    term_e       respKind, doneStatus;
    term_e       q[$];
    int          fail_count, checks_done, ts, nd, cyc;

    bus_term_if link ();
    bus_fault_ctrl i_bus_fault_ctrl (.*);
    bus_term_responder #(.TIMEOUT_NS(100)) i_bus_term_responder (.*);
    bus_term_monitor i_bus_term_monitor (
        .ref_clk(ref_clk), .resetn(resetn), .transferStart(link.transferStart),
        .cycleActive(link.cycleActive), .address(link.address),
        .transferKindHi(link.transferKindHi), .transferKindLo(link.transferKindLo),
        .accessModifier(link.accessModifier), .readNotWrite(link.readNotWrite),
        .procStateOut(link.procStateOut), .driveEn_n(link.driveEn_n),
        .transferAck_n(link.transferAck_n), .transferErrorAck_n(link.transferErrorAck_n),
        .busOwnershipGrant_n(link.busOwnershipGrant_n));

    // ****************************************
    // Clock, watcher, time limit
    // ****************************************
    always #25 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            summarize();
        end
        if (link.transferStart === 1'b1) ts <= ts + 1;
        if (resetn) check("echo", cycleSeen, ps);
        ps <= link.transferStart === 1'b1;
        seen <= clr ? 7'h00 : seen | {accessErrExc, illegalExc, lineInvalidate,
                 lineNotCached, dirtyRestore, lineKeepValid, timedOut};
        if (resetn && doneValid === 1'b1) begin
            nd <= nd + 1;
            if (q.size() > 0) check("status", doneStatus, q.pop_front());
            else if (!reqStacking) check("done", 1, 0);
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(string nm, logic [31:0] got, logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // One access; TERM_WAIT means no answer, so the system end times out
    task automatic op(access_e k, logic [8:0] f, term_e r, logic [6:0] ex);
        int t0, n0, n;
        @(posedge ref_clk);
        #1;
        check("ready", reqReady, 1);
        t0 = ts;
        n0 = nd;
        reqKind = k;
        {reqLine, reqLock, reqPrefetch, reqMisaligned, reqNeedAny,
         reqReplaceValid, reqReplaceDirty, reqWriteThrough, reqStacking} = f;
        reqAddr = $urandom;
        reqModifier = $urandom;
        respKind = r;
        respValid = (r != TERM_WAIT);
        clr = 1;
        reqValid = 1;
        if (!(f[0] && r == TERM_ERROR))
            q.push_back(r inside {TERM_ERROR, TERM_WAIT} ? TERM_ERROR : TERM_NORMAL);
        @(posedge ref_clk);
        #1;
        reqValid = 0;
        clr = 0;
        if (r == TERM_RETRY) begin
            for (n = 0; n < 200 && ts < t0 + 3; n++) @(posedge ref_clk);
            #1;
            check("hold", link.indivisibleHold, f[7]);
            respKind = TERM_NORMAL;
        end
        for (n = 0; n < 200 && nd == n0 && halted !== 1'b1; n++) @(posedge ref_clk);
        repeat (2) @(posedge ref_clk);
        #1;
        if (ex != 7'h7f) check("flags", seen, ex);
        if (!f[8]) check("addr", seenAddr, k == ACC_BREAKPOINT_OP ? 32'h0 : reqAddr);
        check("ack kind", seenAck, k == ACC_BREAKPOINT_OP);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        int i;
        {ref_clk, resetn, reqValid, instrUsed, instrDiscard, pushSnooped, clr} = '0;
        {reqLine, reqLock, reqPrefetch, reqMisaligned, reqNeedAny,
         reqReplaceValid, reqReplaceDirty, reqWriteThrough, reqStacking} = '0;
        {ce, grantEnable, respValid, reqAddr, reqModifier, reqNeedBeat} = {3'h6, 37'h0};
        {reqKind, respKind, seen, cyc, ts, nd} = '0;
        void'($urandom(32'h518915a8));
        repeat (2) @(posedge ref_clk);
        #1;
        resetn = 1;
        op(ACC_READ, 9'h000, TERM_NORMAL, 7'h00);
        op(ACC_READ, 9'h010, TERM_ERROR, 7'h40);
        op(ACC_WRITE, 9'h002, TERM_ERROR, 7'h42);
        op(ACC_BREAKPOINT_OP, 9'h000, TERM_NORMAL, 7'h20);
        op(ACC_BREAKPOINT_OP, 9'h000, TERM_ERROR, 7'h20);
        op(ACC_BREAKPOINT_OP, 9'h000, TERM_RETRY, 7'h20);
        op(ACC_READ, 9'h010, TERM_WAIT, 7'h41);
        op(ACC_READ, 9'h100, TERM_NORMAL, 7'h00);
        op(ACC_READ, 9'h11c, TERM_ERROR, 7'h54);
        op(ACC_READ, 9'h130, TERM_ERROR, 7'h40);
        op(ACC_READ, 9'h100, TERM_ERROR, 7'h08);
        op(ACC_PUSH_FLUSH, 9'h000, TERM_ERROR, 7'h50);
        op(ACC_PUSH_REPL, 9'h000, TERM_ERROR, 7'h42);
        op(ACC_READ, 9'h080, TERM_RETRY, 7'h00);
        op(ACC_WRITE, 9'h080, TERM_RETRY, 7'h00);
        op(ACC_WRITE, 9'h001, TERM_RETRY, 7'h00);
        check("no halt", halted, 0);
        for (i = 0; i < 2; i++) begin
            op(ACC_READ, 9'h040, TERM_ERROR, 7'h00);
            check("pending", deferredPending, 1);
            {instrUsed, instrDiscard} = (i == 0) ? 2'h2 : 2'h1;
            @(posedge ref_clk);
            #1;
            {instrUsed, instrDiscard} = 2'h0;
            repeat (2) @(posedge ref_clk);
            #1;
            check("used", seen, (i == 0) ? 7'h40 : 7'h00);
            check("cleared", deferredPending, 0);
        end
        op(ACC_WRITE, 9'h001, TERM_ERROR, 7'h7f);
        check("halt", halted, 1);
        check("state", link.procStateOut, 4'h5);
        grantEnable = 0;
        repeat (3) @(posedge ref_clk);
        #1;
        check("release", link.driveEn_n, 1);
        summarize();
    end
endmodule

`default_nettype wire
